// >>> logic/tpd_test_port.sv
`timescale 1ns/1ps
`default_nettype none
module tpd_test_port (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [tpd_pkg::TP_N-1:0] tp_in,
  output logic [tpd_pkg::TP_N-1:0] tp_out,
  output logic [tpd_pkg::TP_N-1:0] tp_oe,
  output logic [tpd_pkg::TP_N-1:0] tp_pulldown_en,
  input wire logic sel_wr_en,
  input wire logic [2:0] sel_wr_index,
  input wire logic [tpd_pkg::SEL_W-1:0] sel_wr_value,
  input wire logic var_step_wr_en,
  input wire logic [23:0] var_step_value,
  output logic [2:0] test_mode,
  output logic [3:0] ctrl_option,
  output logic capture_done
);
  import tpd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Storage.
  logic [TP_N-1:0] pin_meta_reg;
  logic [TP_N-1:0] pin_sync_reg;
  logic capture_done_reg;
  logic [TP_N-1:0] strap_reg;
  logic [SEL_W-1:0] sel_reg [TP_N];
  logic [TP_N-1:0] tp_out_reg;
  logic [TP_N-1:0] tp_oe_reg;
  logic [TP_N-1:0] pulldown_reg;
  logic [23:0] var_step_reg;
  logic sw_touched_reg;

  tpd_clk_if clk_bus ();

  tpd_nco_bank u_nco (
    .clock(clock),
    .rst_n(rst_n),
    .clk_bus(clk_bus)
  );

  // Elaboration refuses a port shape that the fixed select map cannot serve.
  if (TP_N != 8 || SEL_W != 3) begin : g_bad_shape
    $error("tpd_test_port supports eight points with three-bit selects");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strap synchroniser; no reset so the pins are tracked while reset is held.
  always_ff @(posedge clock) begin
    pin_meta_reg <= tp_in;
    pin_sync_reg <= pin_meta_reg;
  end

  // Decoding of the code being captured and of software requests.
  wire capture_now = !capture_done_reg;
  wire is_clkdbg = pin_sync_reg[MODE_MSB:MODE_LSB] == MODE_CLKDBG;
  wire sw_write = sel_wr_en && capture_done_reg;
  wire step_low = var_step_value < STEP_VMIN;
  wire step_high = var_step_value > STEP_VMAX;
  wire [23:0] step_clamped = step_low ? STEP_VMIN : (step_high ? STEP_VMAX : var_step_value);

  ////////////////////////////////////////////////////////////////////////////
  // One-shot capture on the first edge after reset release.
  // capture once only
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      capture_done_reg <= 1'b0;
      strap_reg <= 8'h00;
    end else if (capture_now) begin
      capture_done_reg <= 1'b1;
      strap_reg <= pin_sync_reg;
    end
  end

  // The pulldown is always on; it matters only while the pins are inputs.
  // internal pulldown enable
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pulldown_reg <= PULLDOWN_ALL;
    end else begin
      pulldown_reg <= PULLDOWN_ALL;
    end
  end

  // Variable clock rate is clamped to its supported span.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      var_step_reg <= VAR_STEP_RST;
    end else if (var_step_wr_en) begin
      var_step_reg <= step_clamped;
    end
  end
  assign clk_bus.var_step = var_step_reg;

  // Remembers that software overrode a default, used only for checking.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sw_touched_reg <= 1'b0;
    end else if (sw_write) begin
      sw_touched_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-point source selection and output stage.
  for (genvar i = 0; i < TP_N; i++) begin : g_tp
    // Only the clock-debug code enables drivers by default; any other code
    // leaves the point quiet.
    wire [SEL_W-1:0] dflt_sel = is_clkdbg ? DBG_MAP[i*SEL_W +: SEL_W] : SEL_HIZ;
    wire hit = sw_write && (sel_wr_index == 3'(i));
    logic src;

    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        sel_reg[i] <= SEL_HIZ;
      end else if (capture_now) begin
        sel_reg[i] <= dflt_sel;
      end else if (hit) begin
        sel_reg[i] <= sel_wr_value;
      end
    end

    always_comb begin
      case (sel_reg[i])
        SEL_HIGH: src = 1'b1;
        SEL_CLK60: src = clk_bus.dbg_clk[0];
        SEL_CLK30: src = clk_bus.dbg_clk[1];
        SEL_CLKVAR: src = clk_bus.dbg_clk[2];
        SEL_CLK7P5: src = clk_bus.dbg_clk[3];
        default: src = 1'b0;
      endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        tp_out_reg[i] <= 1'b0;
        tp_oe_reg[i] <= 1'b0;
      end else begin
        tp_out_reg[i] <= src;
        tp_oe_reg[i] <= capture_done_reg && (sel_reg[i] != SEL_HIZ);
      end
    end
  end

  // Outputs straight from flip-flops.
  assign tp_out = tp_out_reg;
  assign tp_oe = tp_oe_reg;
  assign tp_pulldown_en = pulldown_reg;
  assign test_mode = strap_reg[MODE_MSB:MODE_LSB];
  assign ctrl_option = strap_reg[OPT_MSB:OPT_LSB];
  assign capture_done = capture_done_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  a_oe_off_reset: assert property (@(posedge clock) disable iff (!rst_n)
    !capture_done_reg |=> tp_oe == 8'h00)
    else $error("test point driven before capture finished");

  a_strap_capture: assert property (@(posedge clock) disable iff (!rst_n)
    rst_n && !capture_done_reg |=> strap_reg == $past(pin_sync_reg) && capture_done_reg)
    else $error("strap code not loaded on release");

  a_strap_hold: assert property (@(posedge clock) disable iff (!rst_n)
    capture_done_reg |=> $stable(strap_reg) && capture_done_reg)
    else $error("strap code changed after capture");

  a_pulldown_on: assert property (@(posedge clock) disable iff (!rst_n)
    tp_pulldown_en == 8'hFF)
    else $error("pulldown released");

  a_quiet_mode: assert property (@(posedge clock) disable iff (!rst_n)
    capture_done_reg && strap_reg[2:0] != MODE_CLKDBG && !sw_touched_reg |-> tp_oe == 8'h00)
    else $error("quiet mode drives a test point");

  a_option_field: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(capture_done_reg) |-> ctrl_option == $past(pin_sync_reg[6:3]))
    else $error("option field wrong");

  a_dbg_clocks: assert property (@(posedge clock) disable iff (!rst_n)
    capture_done_reg && sel_reg[0] == SEL_CLK60 && sel_reg[1] == SEL_CLK30
    |=> tp_out[0] == $past(clk_bus.dbg_clk[0]) && tp_out[1] == $past(clk_bus.dbg_clk[1]))
    else $error("debug clock not routed");

  a_dbg_levels: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(capture_done_reg) && strap_reg[2:0] == MODE_CLKDBG
    |=> tp_oe == 8'hFF && tp_out[6:3] == 4'hD)
    else $error("clock debug levels wrong");

  a_sw_select: assert property (@(posedge clock) disable iff (!rst_n)
    sw_write |=> sel_reg[$past(sel_wr_index)] == $past(sel_wr_value))
    else $error("software selection not taken");

  a_oe_follows: assert property (@(posedge clock) disable iff (!rst_n)
    capture_done_reg && sel_reg[7] == SEL_HIZ |=> !tp_oe[7])
    else $error("undriven selection enables output");

  a_quiet_defaults: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(capture_done_reg) && strap_reg[MODE_MSB:MODE_LSB] != MODE_CLKDBG
    |-> sel_reg[0] == SEL_HIZ && sel_reg[7] == SEL_HIZ)
    else $error("quiet code loaded a driving default");

  a_step_clamp: assert property (@(posedge clock) disable iff (!rst_n)
    var_step_reg >= STEP_VMIN && var_step_reg <= STEP_VMAX)
    else $error("variable clock step outside its span");
endmodule
`default_nettype wire

// >>> include/tpd_pkg.sv
package tpd_pkg;
  // Port shape.
  localparam int TP_N = 8;
  localparam int SEL_W = 3;
  localparam int ACC_W = 24;
  localparam int NCO_N = 4;

  // Output source selection codes, one per test point.
  localparam logic [2:0] SEL_HIZ = 3'h0;
  localparam logic [2:0] SEL_LOW = 3'h1;
  localparam logic [2:0] SEL_HIGH = 3'h2;
  localparam logic [2:0] SEL_CLK60 = 3'h3;
  localparam logic [2:0] SEL_CLK30 = 3'h4;
  localparam logic [2:0] SEL_CLKVAR = 3'h5;
  localparam logic [2:0] SEL_CLK7P5 = 3'h6;

  // Captured low-order strap codes; bit 7 is a don't-care.
  localparam logic [2:0] MODE_QUIET = 3'h0;
  localparam logic [2:0] MODE_CLKDBG = 3'h2;

  // Strap field positions.
  localparam int MODE_LSB = 0;
  localparam int MODE_MSB = 2;
  localparam int OPT_LSB = 3;
  localparam int OPT_MSB = 6;

  // Clock-debug default map, test point 7 in the top three bits.
  localparam logic [23:0] DBG_MAP = {SEL_CLK7P5, SEL_HIGH, SEL_HIGH, SEL_LOW,
                                     SEL_HIGH, SEL_CLKVAR, SEL_CLK30, SEL_CLK60};

  // Rates in kHz and the oscillator steps derived from them.
  localparam longint CLK_KHZ = 100000;
  localparam longint F60_KHZ = 60000;
  localparam longint F30_KHZ = 30000;
  localparam longint F7P5_KHZ = 7500;
  localparam longint FVAR_MIN_KHZ = 700;
  localparam longint FVAR_MAX_KHZ = 22500;
  localparam logic [23:0] STEP_60 = 24'((F60_KHZ << ACC_W) / CLK_KHZ);
  localparam logic [23:0] STEP_30 = 24'((F30_KHZ << ACC_W) / CLK_KHZ);
  localparam logic [23:0] STEP_7P5 = 24'((F7P5_KHZ << ACC_W) / CLK_KHZ);
  localparam logic [23:0] STEP_VMIN = 24'((FVAR_MIN_KHZ << ACC_W) / CLK_KHZ);
  localparam logic [23:0] STEP_VMAX = 24'((FVAR_MAX_KHZ << ACC_W) / CLK_KHZ);

  // Reset values.
  localparam logic [7:0] PULLDOWN_ALL = 8'hFF;
  localparam logic [23:0] VAR_STEP_RST = STEP_VMIN;
endpackage

// >>> include/tpd_clk_if.sv
`timescale 1ns/1ps
`default_nettype none
// Carries the variable-rate step to the oscillator bank and its clocks back.
interface tpd_clk_if;
  logic [23:0] var_step;
  logic [3:0] dbg_clk;
  modport gen (input var_step, output dbg_clk);
  modport use_side (output var_step, input dbg_clk);
endinterface
`default_nettype wire

// >>> logic/tpd_nco_bank.sv
`timescale 1ns/1ps
`default_nettype none
module tpd_nco_bank (
  input wire logic clock,
  input wire logic rst_n,
  tpd_clk_if.gen clk_bus
);
  import tpd_pkg::*;

  logic [23:0] step [NCO_N];
  logic [23:0] acc_reg [NCO_N];

  // Index 0..3 are 60 MHz, 30 MHz, variable and 7.5 MHz.
  assign step[0] = STEP_60;
  assign step[1] = STEP_30;
  assign step[2] = clk_bus.var_step;
  assign step[3] = STEP_7P5;

  // A phase accumulator gives the exact average rate; rates above half the
  // system clock fold down, so 60 MHz is only faithful on a faster clock.
  for (genvar g = 0; g < NCO_N; g++) begin : g_nco
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        acc_reg[g] <= 24'h000000;
      end else begin
        acc_reg[g] <= acc_reg[g] + step[g];
      end
    end
    assign clk_bus.dbg_clk[g] = acc_reg[g][ACC_W-1];
  end
endmodule
`default_nettype wire

// >>> verification/tpd_board_model.sv
`timescale 1ns/1ps
`default_nettype none
// Board side of the test points: strap pullups, and the level a probe sees.
module tpd_board_model (
  input wire logic [7:0] strap_up,
  input wire logic [7:0] tp_out,
  input wire logic [7:0] tp_oe,
  input wire logic [7:0] tp_pulldown_en,
  output logic [7:0] tp_in
);
  // Device drive wins, then the stronger external pullup, then the pulldown.
  // strap pullups
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (tp_oe[i]) begin
        tp_in[i] = tp_out[i];
      end else if (strap_up[i]) begin
        tp_in[i] = 1'b1;
      end else if (tp_pulldown_en[i]) begin
        tp_in[i] = 1'b0;
      end else begin
        tp_in[i] = ~tp_out[i]; // A floating pin must not look like the last drive.
      end
    end
  end
endmodule
`default_nettype wire

// >>> verification/tb_test_point_strap_debug_port.sv
`timescale 1ns/1ps
`default_nettype none
module tb_test_point_strap_debug_port;
  import tpd_pkg::*;
  logic clock = 1'b0;
  logic rst_n;
  logic [7:0] strap_up = 8'h00;
  logic sel_wr_en = 1'b0;
  logic [2:0] sel_wr_index = 3'h0;
  logic [2:0] sel_wr_value = 3'h0;
  logic var_step_wr_en = 1'b0;
  logic [23:0] var_step_value = 24'h000000;
  wire logic [7:0] tp_in;
  wire logic [7:0] tp_out;
  wire logic [7:0] tp_oe;
  wire logic [7:0] tp_pd;
  wire logic [2:0] test_mode;
  wire logic [3:0] ctrl_option;
  wire logic capture_done;
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;
  logic [15:0] lfsr = 16'h4C94;
  logic [7:0] s;
  int n;

  tpd_test_port tpd_test_port_inst (.clock(clock), .rst_n(rst_n), .tp_in(tp_in), .tp_out(tp_out),
    .tp_oe(tp_oe), .tp_pulldown_en(tp_pd), .sel_wr_en(sel_wr_en), .sel_wr_index(sel_wr_index),
    .sel_wr_value(sel_wr_value), .var_step_wr_en(var_step_wr_en), .var_step_value(var_step_value),
    .test_mode(test_mode), .ctrl_option(ctrl_option), .capture_done(capture_done));
  tpd_board_model tpd_board_model_inst (.strap_up(strap_up), .tp_out(tp_out), .tp_oe(tp_oe),
    .tp_pulldown_en(tp_pd), .tp_in(tp_in));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, and a ceiling well above the roughly 7200 cycles the run needs.
  always #5 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles > 40000) begin
      fail_count++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sixteen-bit shift register, so every run sees the same values.
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Above half the clock rate a sampled clock folds back below it.
  function automatic int exp_edges(input int khz);
    return (khz > 50000) ? (100000 - khz) / 100 : khz / 100;
  endfunction
  function automatic logic [7:0] exp_oe(input logic [7:0] st);
    return (st[2:0] == MODE_CLKDBG) ? 8'hFF : 8'h00;
  endfunction

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // Rising edges over 1000 cycles; two edges of slack cover phase at the start.
  task automatic check_rate(input int idx, input int khz);
    logic prev;
    n = 0;
    prev = tp_in[idx];
    repeat (1000) begin
      @(posedge clock);
      #1;
      if (tp_in[idx] === 1'b1 && prev === 1'b0) n++;
      prev = tp_in[idx];
    end
    checked++;
    if (n < exp_edges(khz) - 2 || n > exp_edges(khz) + 2) begin
      fail_count++;
      $display("ERROR %0t: pin %0d gave %0d edges", $time, idx, n);
    end
  endtask
  // Reset with the given pullups, then release and look at the capture edge.
  task automatic do_reset(input logic [7:0] st);
    @(posedge clock);
    rst_n <= 1'b0;
    strap_up <= st;
    repeat (10) @(posedge clock);
    #1;
    check(tp_oe, 8'h00);
    check(capture_done, 1'b0);
    @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    #1;
    check(tp_oe, 8'h00);
    check(test_mode, st[2:0]);
    check(ctrl_option, st[6:3]);
    check(capture_done, 1'b1);
    @(posedge clock);
    #1;
  endtask
  task automatic sel_write(input logic [2:0] idx, input logic [2:0] v);
    @(posedge clock);
    sel_wr_en <= 1'b1;
    sel_wr_index <= idx;
    sel_wr_value <= v;
    @(posedge clock);
    sel_wr_en <= 1'b0;
    @(posedge clock);
    #1;
  endtask
  task automatic step_write(input logic [23:0] v);
    @(posedge clock);
    var_step_wr_en <= 1'b1;
    var_step_value <= v;
    @(posedge clock);
    var_step_wr_en <= 1'b0;
    #1;
  endtask
  task automatic finish_test();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Open straps first, then random straps with the debug code forced in half.
  initial begin
    // A real falling edge at time zero, so the asynchronous reset takes hold.
    rst_n <= 1'b0;
    do_reset(8'h00);
    check(tp_pd, 8'hFF);
    check(tp_in, 8'h00);
    check(tp_oe, 8'h00);
    for (int i = 0; i < 6; i++) begin
      lfsr = lfsr_next(lfsr);
      s = lfsr[7:0];
      if (i % 2 == 0) s[2:0] = MODE_CLKDBG;
      do_reset(s);
      check(tp_oe, exp_oe(s));
      if (s[2:0] == MODE_CLKDBG) check(tp_out[6:3], 4'hD);
      @(posedge clock);
      strap_up <= ~s;
      repeat (3) @(posedge clock);
      #1;
      check(test_mode, s[2:0]);
      check(ctrl_option, s[6:3]);
    end
    do_reset(8'h02);
    check_rate(0, 60000);
    check_rate(1, 30000);
    check_rate(7, 7500);
    check_rate(2, 700);
    step_write(STEP_VMAX);
    check_rate(2, 22500);
    step_write(24'h000001);
    check_rate(2, 700);
    step_write(24'hFFFFFF);
    check_rate(2, 22500);
    // Every source code once, on random points.
    for (int v = 0; v < 8; v++) begin
      lfsr = lfsr_next(lfsr);
      sel_write(lfsr[2:0], 3'(v));
      check(tp_oe[lfsr[2:0]], (v != 0));
      if (v == 1 || v == 2 || v == 7) check(tp_out[lfsr[2:0]], (v == 2));
    end
    finish_test();
  end
endmodule
`default_nettype wire
